// File: design/pisosr_pkg.sv
// constants, modes and pin bundle of the parallel-in serial-out shifter
`default_nettype none
package pisosr_pkg;
  localparam int          PISOSR_STAGES    = 8;      // stages in the shift chain
  localparam int          PISOSR_FIFO_DEP  = 8;      // words in the shifted-out bit fifo
  localparam int          PISOSR_FIFO_WID  = 1;      // one bit per shift event
  localparam logic [7:0]  PISOSR_STAGE_RST = 8'h00;  // chain contents after reset
  localparam logic        PISOSR_GATE_RST  = 1'h0;   // nor gate history after reset

  // what the chain does in a given cycle
  typedef enum logic [1:0] {
    PISOSR_MODE_HOLD  = 2'b00,
    PISOSR_MODE_LOAD  = 2'b01,
    PISOSR_MODE_SHIFT = 2'b10
  } pisosr_mode_t;

  // the host-driven pins, sampled on core_clk
  typedef struct packed {
    logic       shift_load_n;  // low loads / follows parallel inputs
    logic       clk_pin;       // shift clock pin
    logic       clk_inh;       // clock inhibit pin
    logic       ser_in;        // serial data into the first stage
    logic [7:0] par_in;        // [0] feeds first stage .. [7] feeds last
  } pisosr_pins_t;
endpackage
`default_nettype wire

// File: design/pisosr_shifter.sv
// eight-stage parallel-in serial-out shifter with a fifo of shifted-out bits
//
// Behaviour
// - eight stages shift first toward last
// - load falling edge copies parallel inputs at once
// - load low: stages follow inputs A..H
// - load high: parallel inputs ignored
// - shift clock is NOR of clock, inhibit
// - either clock pin low enables the other
// - rising clock: first takes serial, others shift
// - no clock edge or inhibit held high: hold
// - last stage on true and inverted outputs
`default_nettype none

module pisosr_fifo
  import pisosr_pkg::*;
#(
  parameter int WIDTH = PISOSR_FIFO_WID,
  parameter int DEPTH = PISOSR_FIFO_DEP
) (
  input  wire logic             core_clk,  // system clock
  input  wire logic             resetn,    // async reset, active low
  input  wire logic             in_valid,  // push request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word pushed
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // consumer takes word
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_q, wr_ptr_d;
  logic [PW-1:0]    rd_ptr_q, rd_ptr_d;
  logic [CW-1:0]    count_q,  count_d;
  logic             ready_q,  ready_d;
  logic             valid_q,  valid_d;
  logic [WIDTH-1:0] head_q,   head_d;
  logic             push, pop;

  // flags and head word are registered so every handshake output is a flop
  always_comb begin
    push     = in_valid && ready_q;
    pop      = out_ready && valid_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    count_d  = count_q;
    if (push) begin
      wr_ptr_d = (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + PW'(1);
    end
    if (pop) begin
      rd_ptr_d = (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + PW'(1);
    end
    if (push && !pop) begin
      count_d = count_q + CW'(1);
    end else if (pop && !push) begin
      count_d = count_q - CW'(1);
    end
    ready_d = (count_d != FULL_CNT);
    valid_d = (count_d != '0);
    // a word written into the slot about to be read bypasses the memory
    if (push && (wr_ptr_q == rd_ptr_d)) begin
      head_d = in_data;
    end else begin
      head_d = mem[rd_ptr_d];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'h1;
      valid_q  <= 1'h0;
      head_q   <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
      valid_q  <= valid_d;
      head_q   <= head_d;
    end
  end

  // storage has no reset; empty flag hides stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  assign in_ready  = ready_q;
  assign out_valid = valid_q;
  assign out_data  = head_q;

  default clocking fcb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // occupancy never passes the depth
  AST_FIFO_COUNT_MAX: assert property (
    count_q <= FULL_CNT)
    else $error("fifo count above its depth");

  // registered flags must agree with the occupancy they stand for
  AST_FIFO_FLAGS: assert property (
    (in_ready == (count_q != FULL_CNT)) && (out_valid == (count_q != '0)))
    else $error("fifo flags disagree with occupancy");

  // the head register must track the word at the read pointer
  AST_FIFO_HEAD: assert property (
    out_valid |-> out_data == mem[rd_ptr_q])
    else $error("fifo head word is stale");

  // a refused push leaves the occupancy alone unless a pop happens
  AST_FIFO_FULL_KEEP: assert property (
    !in_ready && !out_ready |=> !in_ready && $stable(count_q))
    else $error("full fifo changed without a pop");
endmodule

module pisosr_shifter
  import pisosr_pkg::*;
#(
  parameter int FIFO_DEPTH = PISOSR_FIFO_DEP
) (
  input  wire logic         core_clk,  // 100 MHz system clock
  input  wire logic         resetn,    // async reset, active low
  input  wire pisosr_pins_t pins,      // host pins, synchronous to core_clk
  output logic              ser_out,   // last stage, true
  output logic              ser_out_n, // last stage, inverted
  output logic              bit_valid, // shifted-out bit waiting
  output logic              bit_data,  // oldest shifted-out bit
  input  wire logic         bit_ready, // consumer takes the bit
  output logic              bit_room   // fifo can take another bit
);
  logic [PISOSR_STAGES-1:0] stages_q, stages_d;
  logic                     gate_q,   gate_d;
  logic                     inv_q,    inv_d;
  logic                     gate_now;
  logic                     shift_fire;
  pisosr_mode_t             mode;

  // nor of clock and inhibit; its falling edge is a rising edge on either pin while the other is low
  always_comb begin
    gate_now   = !(pins.clk_pin || pins.clk_inh);
    gate_d     = gate_now;
    shift_fire = pins.shift_load_n && gate_q && !gate_now;
    if (!pins.shift_load_n) begin
      mode = PISOSR_MODE_LOAD;
    end else if (shift_fire) begin
      mode = PISOSR_MODE_SHIFT;
    end else begin
      mode = PISOSR_MODE_HOLD;
    end
  end

  // chain next value; load overrides clock, inhibit and serial data
  always_comb begin
    case (mode)
      PISOSR_MODE_LOAD: begin
        stages_d = pins.par_in;
      end
      PISOSR_MODE_SHIFT: begin
        stages_d = {stages_q[PISOSR_STAGES-2:0], pins.ser_in};
      end
      default: begin
        stages_d = stages_q;
      end
    endcase
    inv_d = !stages_d[PISOSR_STAGES-1];
  end

  // inhibit raised while the clock is low still looks like an edge here
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      stages_q <= PISOSR_STAGE_RST;
      gate_q   <= PISOSR_GATE_RST;
      inv_q    <= !PISOSR_STAGE_RST[PISOSR_STAGES-1];
    end else begin
      stages_q <= stages_d;
      gate_q   <= gate_d;
      inv_q    <= inv_d;
    end
  end

  // only the last stage leaves the block
  assign ser_out   = stages_q[PISOSR_STAGES-1];
  assign ser_out_n = inv_q;

  // bits pushed off the end are kept; dropped only when fifo is full
  pisosr_fifo #(
    .WIDTH (PISOSR_FIFO_WID),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (shift_fire),
    .in_ready  (bit_room),
    .in_data   (stages_q[PISOSR_STAGES-1]),
    .out_valid (bit_valid),
    .out_ready (bit_ready),
    .out_data  (bit_data)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // load held low over two edges
  sequence s_load_held;
    !pins.shift_load_n [*2];
  endsequence

  // clock pin rises with inhibit low on both edges, not on the first edge out of reset
  sequence s_clk_rise_open;
    $past(resetn) && pins.shift_load_n && !pins.clk_inh && !$past(pins.clk_inh) && $rose(pins.clk_pin);
  endsequence

  // inhibit pin used as the clock while the clock pin is held low
  sequence s_inh_rise_open;
    $past(resetn) && pins.shift_load_n && !pins.clk_pin && !$past(pins.clk_pin) && $rose(pins.clk_inh);
  endsequence

  // either pin high blocks the gate, then load stays high for one more edge
  sequence s_gate_blocked;
    (pins.clk_pin || pins.clk_inh) ##1 pins.shift_load_n;
  endsequence

  // every stage but the first takes its predecessor
  AST_SHIFT_CHAIN: assert property (
    shift_fire |=> stages_q[PISOSR_STAGES-1:1] == $past(stages_q[PISOSR_STAGES-2:0]))
    else $error("chain did not move one stage on shift");

  // falling load copies the parallel inputs at once
  AST_LOAD_EDGE: assert property (
    $fell(pins.shift_load_n) |=> stages_q == $past(pins.par_in))
    else $error("load edge did not copy parallel inputs");

  // held load keeps following the parallel inputs
  AST_LOAD_FOLLOW: assert property (
    s_load_held |=> stages_q == $past(pins.par_in))
    else $error("stages not following parallel inputs");

  // without a shift, load high freezes the chain
  AST_LOAD_BLOCKED: assert property (
    pins.shift_load_n && !shift_fire |=> $stable(stages_q))
    else $error("stages changed with load high and no shift");

  // inhibit held high over two edges blocks shifting
  AST_INHIBIT_HOLD: assert property (
    pins.shift_load_n && pins.clk_inh && $past(pins.clk_inh) |=> $stable(stages_q))
    else $error("shift happened with inhibit held high");

  // a blocked gate on one edge leaves nothing to fall on the next
  AST_GATE_BLOCKS: assert property (
    s_gate_blocked |=> $stable(stages_q))
    else $error("shift happened through a blocked gate");

  // open clock edge shifts serial data in and leaves a bit waiting in the fifo
  AST_CLOCK_ENABLED: assert property (
    s_clk_rise_open |=> stages_q[0] == $past(pins.ser_in) ##0 bit_valid)
    else $error("clock edge with inhibit low did not shift");

  // inhibit rising with the clock low also clocks the chain
  AST_INH_AS_CLOCK: assert property (
    s_inh_rise_open |=> stages_q[0] == $past(pins.ser_in))
    else $error("inhibit edge with clock low did not shift");

  // last stage takes the seventh stage's old value
  AST_LAST_TAKES_PREV: assert property (
    shift_fire |=> ser_out == $past(stages_q[PISOSR_STAGES-2]))
    else $error("last stage did not take its predecessor");

  // both pins steady low: the gate sits high and nothing moves
  AST_STEADY_LOW_HOLD: assert property (
    pins.shift_load_n && !pins.clk_pin && !pins.clk_inh && !$past(pins.clk_pin) && !$past(pins.clk_inh)
    |=> $stable(stages_q))
    else $error("stages changed with clock steady low");

  // load low wins over a clock edge in the same cycle
  AST_LOAD_OVER_CLOCK: assert property (
    !pins.shift_load_n && $rose(pins.clk_pin) |=> stages_q == $past(pins.par_in))
    else $error("clock edge overrode a load");

  // outputs stay put while the chain holds
  AST_HOLD_OUTPUTS: assert property (
    mode == PISOSR_MODE_HOLD |=> $stable(ser_out) && $stable(ser_out_n))
    else $error("outputs moved while the chain held");

  // inverted output kept in its own flop, so it is checked against the true one
  AST_COMPLEMENT: assert property (
    ser_out_n != ser_out)
    else $error("inverted output not the complement");

  // a shift into an empty fifo queues exactly the bit that left
  AST_PUSH_ON_SHIFT: assert property (
    shift_fire && bit_room && !bit_valid |=> bit_valid && bit_data == $past(ser_out))
    else $error("leaving bit not queued");

  // a full fifo with no pop drops the bit but the chain still shifts
  AST_FULL_DROP: assert property (
    shift_fire && !bit_room && !bit_ready |=> !bit_room && stages_q[0] == $past(pins.ser_in))
    else $error("full fifo took a bit or chain stalled");

  // the pin shows the last stage and nothing else
  AST_ONLY_LAST: assert property (
    ##1 ser_out == $past(stages_d[PISOSR_STAGES-1]))
    else $error("serial output not the last stage");
endmodule
`default_nettype wire

// File: verif/pisosr_host.sv
// host model driving the load, clock, inhibit and data pins
`default_nettype none
module pisosr_host
  import pisosr_pkg::*;
(
  input  wire logic   core_clk, // system clock
  output var pisosr_pins_t pins // pins toward the shifter
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle with clock high so the nor gate stays low
  initial pins = {1'h1, 1'h1, 1'h0, 1'h0, 8'h00};
  // load low keeps the chain following the parallel inputs
  task automatic load(input logic [7:0] p);
    @(negedge core_clk);
    pins.clk_pin = 1'h1;
    pins.shift_load_n = 1'h0;
    pins.par_in = p;
    @(posedge core_clk);
  endtask
  // load high with junk on the parallel inputs
  task automatic unload(input logic [7:0] p);
    @(negedge core_clk);
    pins.shift_load_n = 1'h1;
    pins.par_in = p;
    @(posedge core_clk);
  endtask
  // one shift edge on either clock pin, the other held low
  task automatic shift(input logic s, input logic via_inh);
    @(negedge core_clk);
    pins.clk_pin = 1'h0;
    pins.clk_inh = 1'h0;
    pins.ser_in = s;
    @(posedge core_clk);
    @(negedge core_clk);
    if (via_inh) pins.clk_inh = 1'h1;
    else pins.clk_pin = 1'h1;
    @(posedge core_clk);
    // hold time over: serial line no longer shows the bit
    @(negedge core_clk);
    pins.ser_in = ~s;
  endtask
  // inhibit raised only with clock high, then clock toggles
  task automatic inhibit();
    @(negedge core_clk);
    pins.clk_pin = 1'h1;
    @(negedge core_clk);
    pins.clk_inh = 1'h1;
    repeat (4) begin
      @(negedge core_clk);
      pins.clk_pin = ~pins.clk_pin;
    end
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// File: verif/pisosr_shifter_tb_top.sv
// self-checking bench for the parallel-in serial-out shifter
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module pisosr_shifter_tb_top
  import pisosr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, bit_ready, ser_out, ser_out_n, bit_valid, bit_data, bit_room;
  pisosr_pins_t pins;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] st; // model chain, [0] first stage
  logic q[$]; // model of fifo contents
  logic exp_bit; // fifo head the model expects
  pisosr_host host (.core_clk(core_clk), .pins(pins));
  pisosr_shifter #(.FIFO_DEPTH(PISOSR_FIFO_DEP)) uut (.core_clk(core_clk), .resetn(resetn), .pins(pins),
    .ser_out(ser_out), .ser_out_n(ser_out_n), .bit_valid(bit_valid), .bit_data(bit_data),
    .bit_ready(bit_ready), .bit_room(bit_room));
  // free-running 100 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // only the last stage is visible, both polarities
  task automatic chk_out();
    `CHK("ser_out", st[7], ser_out)
    `CHK("ser_out_n", ~st[7], ser_out_n)
  endtask
  // one shift; the bit leaving the last stage goes to the fifo if room
  task automatic do_shift(input logic via_inh);
    logic s;
    s = 1'($urandom);
    host.shift(s, via_inh);
    if (q.size() < PISOSR_FIFO_DEP) q.push_back(st[7]);
    st = {st[6:0], s};
    chk_out();
  endtask
  // watchdog sized well above the expected run
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial begin
    resetn = 1'h0;
    bit_ready = 1'h0;
    void'($urandom(32'h6FCC));
    repeat (3) @(negedge core_clk);
    `CHK("rst ser_out_n", 1'h1, ser_out_n)
    `CHK("rst bit_room", 1'h1, bit_room)
    `CHK("rst bit_valid", 1'h0, bit_valid)
    `CHK("rst ser_out", 1'h0, ser_out)
    resetn = 1'h1;
    repeat (2) begin
      st = 8'($urandom);
      host.load(st);
      @(negedge core_clk) chk_out();
      st = 8'($urandom);
      host.load(st);
      @(negedge core_clk) chk_out();
      host.unload(8'($urandom));
      host.unload(8'($urandom));
      @(negedge core_clk) chk_out();
      host.inhibit();
      @(negedge core_clk) chk_out();
      for (int i = 0; i < 9; i++) do_shift(i % 3 == 2);
      @(negedge core_clk);
      `CHK("bit_room full", 1'h0, bit_room)
      // drain in shift order, checking each bit against the model
      while (q.size() > 0) begin
        @(negedge core_clk);
        `CHK("bit_valid", 1'h1, bit_valid)
        exp_bit = q.pop_front();
        `CHK("bit_data", exp_bit, bit_data)
        bit_ready = 1'h1;
        @(negedge core_clk) bit_ready = 1'h0;
      end
      @(negedge core_clk);
      `CHK("bit_valid empty", 1'h0, bit_valid)
    end
    final_report();
  end
endmodule
`default_nettype wire
